/* dpvo_pkg.sv */
// Purpose: Shared constants for the dual pixel video output formatter
// Assumes: System clock 40 MHz; nominal pixel rate 40 MHz, 20 MHz binned
// Notes:   Link word bit positions follow the 28-bit serializer input
`default_nettype none
package dpvo_pkg;

	// Rates in MHz
	localparam int CLK_MHZ     = 40;
	localparam int PIX_MHZ     = 40;
	localparam int PIX_BIN_MHZ = 20;

	// Least time in ns to whole cycles, rounded up, at least one
	function automatic int nsToCyc(input int ns, input int mhz);
		int c;
		c = (ns * mhz + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// Line valid low times
	localparam int GAP_NS     = 7900;
	localparam int LAST_GAP_NS = 25;
	localparam int STRETCH_NS = 30000;

	// Gap lengths in pixel clock cycles, normal and binned rates
	localparam logic [10:0] GAP_CYC      = 11'(nsToCyc(GAP_NS, PIX_MHZ));
	localparam logic [10:0] LAST_CYC     = 11'(nsToCyc(LAST_GAP_NS, PIX_MHZ));
	localparam logic [10:0] STRETCH_CYC  = 11'(nsToCyc(STRETCH_NS, PIX_MHZ));
	localparam logic [10:0] GAP_CYC_B    =
		11'(nsToCyc(GAP_NS, PIX_BIN_MHZ));
	localparam logic [10:0] LAST_CYC_B   =
		11'(nsToCyc(LAST_GAP_NS, PIX_BIN_MHZ));
	localparam logic [10:0] STRETCH_CYC_B =
		11'(nsToCyc(STRETCH_NS, PIX_BIN_MHZ));

	// Frame geometry: pixel pairs per line, lines per frame
	localparam logic [11:0] LINE_PAIRS  = 12'h200;
	localparam logic [11:0] FRAME_LINES = 12'h400;

	// Default programmable exposure time in system clock cycles
	localparam int EXPO_CYC_DEFAULT = 40000;

	// Serializer input positions of ports A, B and C, bits 0 to 7
	localparam int PORT_A [8] = '{0, 1, 2, 3, 4, 6, 27, 5};
	localparam int PORT_B [8] = '{7, 8, 9, 12, 13, 14, 10, 11};
	localparam int PORT_C [8] = '{15, 18, 19, 20, 21, 22, 16, 17};
	localparam int LV_BIT = 24;
	localparam int FV_BIT = 25;

	// Reset values
	localparam logic [27:0] WORD_RST = 28'h0000000;

	// Exposure sequencer states
	typedef enum logic [2:0] {
		EXP_IDLE  = 3'b001,
		EXP_LEVEL = 3'b010,
		EXP_TIMED = 3'b100
	} dpvo_exp_t;

	// Readout states on the pixel clock side
	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_LINE = 3'b010,
		RD_GAP  = 3'b100
	} dpvo_rd_t;

endpackage
`default_nettype wire

/* dpvo_video_output.sv */
// Purpose: Dual pixel video output formatter with exposure sync input
// Assumes: linkClk is the source of the pixel clock; samples come from
//          logic on linkClk; mode inputs come from logic on clk
// Notes:   Overview of operation
// Overview of operation
// R1 - Sync driver toggles, high at least 4 us
// R2 - Frame rate follows periodic or irregular sync
// R3 - Level-controlled and programmable exposure modes supported
// R4 - Level mode falls start, programmable rises start
// R5 - Pixel clock out, halved when binning
// R6 - Data and qualifiers change on falling edge
// R7 - Frame valid high across whole frame
// R8 - Line valid high per line, low between
// R9 - Data valid only with both qualifiers high
// R10 - Dual 10-bit and dual 8-bit modes selectable
// R11 - Ten-bit mode sends two pixels per cycle
// R12 - Ten-bit odd pixel on A, bits 8-9 B0-B1
// R13 - Ten-bit even on C, bits 8-9 B4-B5
// R14 - Eight-bit mode drops two sample LSBs
// R15 - Eight-bit odd on A, even on B
// R16 - Line valid input 24, frame valid 25
// R17 - Grabber samples on its own chosen edge
// R18 - Pixel pairs leave in line order
// R19 - Normal line gap, last gap always short
// R20 - Sync start during frame stretches next gap
// R21 - Qualifiers and unused inputs zero after reset
`timescale 1ns/1ps
`default_nettype none
module dpvo_video_output
	import dpvo_pkg::*;
#(
	parameter int EXPO_CYCLES = EXPO_CYC_DEFAULT
) (
	// System clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Configuration from logic on clk
	input  wire logic        progExposure,
	input  wire logic        eightBitMode,
	input  wire logic        binning,
	// Exposure sync pin
	input  wire logic        exposure_sync_input,
	// Link side clock and pixel samples on it
	input  wire logic        linkClk,
	input  wire logic [9:0]  oddSample,
	input  wire logic [9:0]  evenSample,
	// Status on clk
	output var  logic        exposing,
	// Link side outputs
	output var  logic        sampleTake,
	output var  logic        serializer_clock_input,
	output var  logic [27:0] serializer_parallel_input
);

	// Build the serializer word from a pixel pair and qualifiers
	function automatic logic [27:0] packWord(input logic [9:0] odd,
		input logic [9:0] even, input logic eight, input logic lv,
		input logic fv);
		logic [27:0] w;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  c;
		w = WORD_RST;
		if (eight) begin
			a = odd[9:2]; // R14
			b = even[9:2]; // R15
			c = 8'h00;
		end else begin
			a = odd[7:0]; // R12
			b = {2'b00, even[9:8], 2'b00, odd[9:8]}; // R13
			c = even[7:0]; // R13
		end
		if (lv && fv) begin
			for (int i = 0; i < 8; i++) begin
				w[PORT_A[i]] = a[i]; // R11
				w[PORT_B[i]] = b[i];
				w[PORT_C[i]] = c[i];
			end
		end
		w[LV_BIT] = lv; // R16
		w[FV_BIT] = fv; // R16
		return w;
	endfunction

	// ---------------- System clock side ----------------

	logic [2:0]  syncPipe;
	logic        syncLvl;
	logic        syncEdge;
	logic        startEdge;
	logic        endEdge;
	dpvo_exp_t   expState;
	logic [31:0] expCnt;
	logic        readTgl;
	logic        stretchTgl;
	logic [2:0]  fvPipe;

	// Three-stage sampling of the sync pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			syncPipe <= 3'b000;
		else
			syncPipe <= {syncPipe[1:0], exposure_sync_input};
	end

	// Level accepted once the later two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			syncLvl <= 1'b0;
		else if (syncPipe[2] == syncPipe[1])
			syncLvl <= syncPipe[2];
	end

	// Edge qualified by exposure mode
	assign syncEdge  = (syncPipe[2] == syncPipe[1]) &&
		(syncPipe[2] != syncLvl); // R2
	assign startEdge = syncEdge &&
		(progExposure ? syncPipe[2] : !syncPipe[2]); // R4
	assign endEdge   = syncEdge && !syncPipe[2];

	// Frame valid seen from the system side
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fvPipe <= 3'b000;
		else
			fvPipe <= {fvPipe[1:0], serializer_parallel_input[FV_BIT]};
	end

	// Exposure sequencer, level or timed end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expState <= EXP_IDLE;
			expCnt   <= 32'h00000000;
			readTgl  <= 1'b0;
		end else begin
			case (expState)
				EXP_IDLE: begin
					if (startEdge && progExposure) begin
						expState <= EXP_TIMED; // R3
						expCnt   <= 32'(EXPO_CYCLES);
					end else if (startEdge) begin
						expState <= EXP_LEVEL; // R3
					end
				end
				EXP_LEVEL: begin
					if (progExposure || (syncEdge && syncPipe[2])) begin
						expState <= EXP_IDLE;
						readTgl  <= !readTgl;
					end
				end
				EXP_TIMED: begin
					if (expCnt <= 32'h00000001) begin
						expState <= EXP_IDLE;
						readTgl  <= !readTgl;
					end else begin
						expCnt <= expCnt - 32'h00000001;
					end
				end
				default: expState <= EXP_IDLE;
			endcase
		end
	end

	// Start edge while a frame is out asks for a long gap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			stretchTgl <= 1'b0;
		else if (startEdge && fvPipe[2] && fvPipe[1])
			stretchTgl <= !stretchTgl; // R20
	end

	// Exposure status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			exposing <= 1'b0;
		else
			exposing <= (expState != EXP_IDLE) || startEdge;
	end

	// ---------------- Link clock side ----------------

	logic [1:0]  linkRst;
	logic        linkRst_n;
	logic [2:0]  readSync;
	logic [2:0]  stretchSync;
	logic [2:0]  eightSync;
	logic [2:0]  binSync;
	logic        eightLvl;
	logic        binLvl;
	logic        divPhase;
	logic        fallTick;
	logic        readPend;
	logic        stretchPend;
	dpvo_rd_t    rdState;
	logic [11:0] pairCnt;
	logic [11:0] lineCnt;
	logic [10:0] gapCnt;
	logic        lineOn;
	logic        frameOn;
	logic        next_lineOn;
	logic        next_frameOn;
	logic        useStretch;
	logic [10:0] gapLen;

	// Reset for the link side, released on linkClk
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n)
			linkRst <= 2'b00;
		else
			linkRst <= {linkRst[0], 1'b1};
	end
	assign linkRst_n = linkRst[1];

	// Toggle crossings into the link side
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			readSync    <= 3'b000;
			stretchSync <= 3'b000;
		end else begin
			readSync    <= {readSync[1:0], readTgl};
			stretchSync <= {stretchSync[1:0], stretchTgl};
		end
	end

	// Mode levels into the link side, unreset so they settle in reset
	always_ff @(posedge linkClk) begin
		eightSync <= {eightSync[1:0], eightBitMode};
		binSync   <= {binSync[1:0], binning};
		if (eightSync[2] == eightSync[1])
			eightLvl <= eightSync[2]; // R10
		if (binSync[2] == binSync[1])
			binLvl <= binSync[2];
	end

	// Pixel clock divider, slower when binning
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			divPhase               <= 1'b0;
			serializer_clock_input <= 1'b0;
		end else begin
			divPhase <= binLvl ? !divPhase : 1'b1;
			if (!binLvl || divPhase)
				serializer_clock_input <= !serializer_clock_input; // R5
		end
	end

	// Edge on which the pixel clock falls
	assign fallTick = serializer_clock_input && (!binLvl || divPhase);

	// Pending readout and stretch, set wins over clear
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			readPend    <= 1'b0;
			stretchPend <= 1'b0;
		end else begin
			if (readSync[2] != readSync[1])
				readPend <= 1'b1; // R2
			else if (fallTick && rdState == RD_IDLE)
				readPend <= 1'b0;
			if (stretchSync[2] != stretchSync[1])
				stretchPend <= 1'b1; // R20
			else if (fallTick && (useStretch || !next_frameOn))
				stretchPend <= 1'b0;
		end
	end

	// Gap choice: last gap short, else stretched or normal
	always_comb begin
		useStretch = 1'b0;
		if (lineCnt == FRAME_LINES - 12'h002)
			gapLen = binLvl ? LAST_CYC_B : LAST_CYC; // R19
		else if (stretchPend) begin
			gapLen     = binLvl ? STRETCH_CYC_B : STRETCH_CYC; // R20
			useStretch = (rdState == RD_LINE) &&
				(pairCnt == LINE_PAIRS - 12'h001);
		end else
			gapLen = binLvl ? GAP_CYC_B : GAP_CYC; // R19
	end

	// Qualifier values for the next falling edge
	always_comb begin
		next_lineOn  = lineOn;
		next_frameOn = frameOn;
		case (rdState)
			RD_IDLE: begin
				next_lineOn  = readPend;
				next_frameOn = readPend;
			end
			RD_LINE: begin
				if (pairCnt == LINE_PAIRS - 12'h001) begin
					next_lineOn = 1'b0; // R8
					if (lineCnt == FRAME_LINES - 12'h001)
						next_frameOn = 1'b0; // R7
				end
			end
			RD_GAP: next_lineOn = (gapCnt == 11'h000);
			default: begin
				next_lineOn  = 1'b0;
				next_frameOn = 1'b0;
			end
		endcase
	end

	// Readout sequencer, advancing on falling pixel clock edges
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			rdState <= RD_IDLE;
			pairCnt <= 12'h000;
			lineCnt <= 12'h000;
			gapCnt  <= 11'h000;
			lineOn  <= 1'b0; // R21
			frameOn <= 1'b0; // R21
		end else if (fallTick) begin // R6
			lineOn  <= next_lineOn;
			frameOn <= next_frameOn;
			case (rdState)
				RD_IDLE: begin
					pairCnt <= 12'h000;
					lineCnt <= 12'h000;
					if (readPend)
						rdState <= RD_LINE;
				end
				RD_LINE: begin
					if (pairCnt == LINE_PAIRS - 12'h001) begin
						pairCnt <= 12'h000;
						if (!next_frameOn)
							rdState <= RD_IDLE;
						else begin
							rdState <= RD_GAP;
							gapCnt  <= gapLen - 11'h001;
						end
					end else
						pairCnt <= pairCnt + 12'h001; // R18
				end
				RD_GAP: begin
					if (gapCnt == 11'h000) begin
						rdState <= RD_LINE;
						lineCnt <= lineCnt + 12'h001;
					end else
						gapCnt <= gapCnt - 11'h001;
				end
				default: rdState <= RD_IDLE;
			endcase
		end
	end

	// Serializer word and sample handshake on the falling edge
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			serializer_parallel_input <= WORD_RST; // R21
			sampleTake                <= 1'b0;
		end else begin
			sampleTake <= fallTick && next_lineOn && next_frameOn;
			if (fallTick)
				serializer_parallel_input <= packWord(oddSample,
					evenSample, eightLvl, next_lineOn,
					next_frameOn); // R9
		end
	end

endmodule // dpvo_video_output
`default_nettype wire

/* dpvo_video_output_props.sv */
// Purpose: Port checker for the dual pixel video output formatter
// Assumes: Sees only the top module ports; two clock domains
// Notes:   Gap counter counts linkClk edges of a line gap
`timescale 1ns/1ps
`default_nettype none
module dpvo_video_output_props
	import dpvo_pkg::*;
#(
	parameter int EXPO_CYCLES = 20
) (
	// Clocks and reset
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        linkClk,
	// Configuration and sync pin
	input wire logic        progExposure,
	input wire logic        eightBitMode,
	input wire logic        binning,
	input wire logic        exposure_sync_input,
	// Samples and outputs
	input wire logic [9:0]  oddSample,
	input wire logic [9:0]  evenSample,
	input wire logic        exposing,
	input wire logic        sampleTake,
	input wire logic        serializer_clock_input,
	input wire logic [27:0] serializer_parallel_input
);
	wire logic [27:0] w  = serializer_parallel_input;
	wire logic        pc = serializer_clock_input;
	logic [11:0]      gapCnt;
	logic [15:0]      expCnt;

	// Expected words for a valid pair in each mode
	function automatic logic [27:0] ten(logic [9:0] o, logic [9:0] e);
		return {o[6], 4'h6, e[5:1], e[7:6], e[0], e[9:8], 4'h0,
			o[9:8], o[5], o[7], o[4:0]};
	endfunction
	function automatic logic [27:0] eig(logic [9:0] o, logic [9:0] e);
		return {o[8], 4'h6, 8'h00, e[7:5], e[9:8], e[4:2], o[7], o[9],
			o[6:2]};
	endfunction

	// Link clocks spent low between lines of a frame
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n)
			gapCnt <= 12'h000;
		else
			gapCnt <= (w[25] && !w[24]) ? gapCnt + 12'h001 : 12'h000;
	end

	// System clocks spent exposing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			expCnt <= 16'h0000;
		else
			expCnt <= exposing ? expCnt + 16'h0001 : 16'h0000;
	end

	sequence s_lvlStart;
		!progExposure && !exposing && $fell(exposure_sync_input);
	endsequence
	sequence s_prgStart;
		progExposure && !exposing && $rose(exposure_sync_input);
	endsequence

	property p_unused;
		@(posedge linkClk) disable iff (!rst_n) !w[23] && !w[26];
	endproperty
	a_unused: assert property (p_unused) else $error("spare bit set");
	property p_pixZero;
		@(posedge linkClk) disable iff (!rst_n)
		!(w[24] && w[25]) |-> (w & 28'hcffffff) == 28'h0000000;
	endproperty
	a_pixZero: assert property (p_pixZero) else $error("pixel bits");
	property p_lvInFv;
		@(posedge linkClk) disable iff (!rst_n) w[24] |-> w[25];
	endproperty
	a_lvInFv: assert property (p_lvInFv) else $error("lv outside fv");
	property p_onFall;
		@(posedge linkClk) disable iff (!rst_n) $changed(w) |-> $fell(pc);
	endproperty
	a_onFall: assert property (p_onFall) else $error("word off edge");
	property p_map10;
		@(posedge linkClk) disable iff (!rst_n) sampleTake && !eightBitMode
		|-> w == ten($past(oddSample), $past(evenSample));
	endproperty
	a_map10: assert property (p_map10) else $error("ten-bit map");
	property p_map8;
		@(posedge linkClk) disable iff (!rst_n) sampleTake && eightBitMode
		|-> w == eig($past(oddSample), $past(evenSample));
	endproperty
	a_map8: assert property (p_map8) else $error("eight-bit map");
	property p_clkDiv;
		@(posedge linkClk) disable iff (!rst_n)
		$rose(pc) |=> if (binning) (pc ##1 !pc) else !pc;
	endproperty
	a_clkDiv: assert property (p_clkDiv) else $error("pixel clock");
	property p_gap;
		@(posedge linkClk) disable iff (!rst_n) $rose(w[24]) && $past(w[25])
		|-> gapCnt inside {12'd2, 12'd4, 12'd632, 12'd1264, 12'd2400};
	endproperty
	a_gap: assert property (p_gap) else $error("line gap length");
	property p_fvStart;
		@(posedge linkClk) disable iff (!rst_n)
		$rose(w[25]) |-> w[24] && sampleTake;
	endproperty
	a_fvStart: assert property (p_fvStart) else $error("frame start");
	property p_lvlStart;
		@(posedge clk) disable iff (!rst_n) s_lvlStart |-> ##[2:6] exposing;
	endproperty
	a_lvlStart: assert property (p_lvlStart) else $error("level start");
	property p_prgStart;
		@(posedge clk) disable iff (!rst_n) s_prgStart |-> ##[2:6] exposing;
	endproperty
	a_prgStart: assert property (p_prgStart) else $error("timed start");
	property p_prgLen;
		@(posedge clk) disable iff (!rst_n) $fell(exposing) && progExposure
		|-> int'(expCnt) >= EXPO_CYCLES && int'(expCnt) <= EXPO_CYCLES + 2;
	endproperty
	a_prgLen: assert property (p_prgLen) else $error("exposure time");
endmodule // dpvo_video_output_props
`default_nettype wire

/* dpvo_grabber_model.sv */
// Purpose: Frame grabber model at the far end of the link
// Assumes: Samples the word on the rising pixel clock edge
// Notes:   Keeps valid pairs, counts lines and the last gap
`timescale 1ns/1ps
`default_nettype none
module dpvo_grabber_model
	import dpvo_pkg::*;
(
	// Link from the camera
	input wire logic        rst_n,
	input wire logic        pixClk,
	input wire logic [27:0] word,
	input wire logic        eight
);
	logic [9:0] oddQ [$];
	logic [9:0] evenQ [$];
	logic [7:0] a;
	logic [7:0] b;
	logic       lvPrev = 1'b0;
	int         lines = 0;
	int         gapLen = 0;
	int         gapRun = 0;

	// Forget everything on reset
	always @(negedge rst_n) begin
		oddQ.delete();
		evenQ.delete();
		lines = 0;
		gapRun = 0;
		gapLen = 0;
		lvPrev = 1'b0;
	end

	// Decode pairs only while both qualifiers are high
	always @(posedge pixClk) begin
		for (int i = 0; i < 8; i++) begin
			a[i] = word[PORT_A[i]];
			b[i] = eight ? word[PORT_B[i]] : word[PORT_C[i]];
		end
		if (word[24] && word[25]) begin
			oddQ.push_back(eight ? {a, 2'h0} : {word[8], word[7], a});
			evenQ.push_back(eight ? {b, 2'h0} : {word[14], word[13], b});
		end
		if (word[25] && !word[24])
			gapRun++;
		if (word[24] && !lvPrev) begin
			lines++;
			gapLen = (gapRun > 0) ? gapRun : gapLen;
			gapRun = 0;
		end
		lvPrev = word[24];
	end
endmodule // dpvo_grabber_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the video output formatter
// Assumes: 40 MHz clk, 30 ns linkClk, exposure time cut to 20 clk
// Notes:   Every scenario restarts from reset; frames are cut short
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	failures++; $display("mismatch %0t: got %h exp %h", $time, a, b); \
	end end
module tb_top
	import dpvo_pkg::*;
;
	logic        clk = 1'b0;
	logic        linkClk = 1'b0;
	logic        rst_n = 1'b0;
	logic        progExposure = 1'b0;
	logic        eightBitMode = 1'b0;
	logic        binning = 1'b0;
	logic        syncPin = 1'b1;
	logic [9:0]  oddSample = 10'h000;
	logic [9:0]  evenSample = 10'h000;
	logic        exposing;
	logic        sampleTake;
	logic        pixClk;
	logic [27:0] word;
	int          failures = 0;
	int          samples_checked = 0;
	int          k = 0;

	dpvo_video_output #(.EXPO_CYCLES(20)) dut (.clk, .rst_n, .progExposure,
		.eightBitMode, .binning, .exposure_sync_input(syncPin), .linkClk,
		.oddSample, .evenSample, .exposing, .sampleTake,
		.serializer_clock_input(pixClk), .serializer_parallel_input(word));
	dpvo_grabber_model grab (.rst_n, .pixClk, .word, .eight(eightBitMode));

	// Clocks of unrelated phase
	always #12.5 clk = ~clk;
	initial begin
		#7;
		forever #15 linkClk = ~linkClk;
	end

	function automatic logic [9:0] pix(int n);
		return 10'(n * 37 + 5);
	endfunction

	// Next pair after each take, first pair again in gaps
	always @(negedge linkClk) begin
		k = (sampleTake === 1'b1) ? k + 1 : (word[24] === 1'b1 ? k : 0);
		oddSample = pix(2 * k + 1);
		evenSample = pix(2 * k + 2);
	end

	// Reset with a mode, then one exposure pulse of 5 us
	task automatic start(bit prog, bit eight, bit bin);
		@(negedge clk);
		rst_n = 1'b0;
		{progExposure, eightBitMode, binning, syncPin} = {prog, eight, bin, !prog};
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (170) @(negedge clk);
		`CHK(word, 28'h0000000)
		syncPin = prog;
		repeat (10) @(negedge clk);
		`CHK(exposing, 1'b1)
		repeat (190) @(negedge clk);
		syncPin = !prog;
		repeat (30) @(negedge clk);
		`CHK(exposing, 1'b0)
	endtask

	task automatic waitLines();
		for (int i = 0; i < 20000 && grab.lines < 2; i++)
			@(posedge linkClk);
		`CHK(grab.lines >= 2, 1'b1)
	endtask

	// First line pair by pair, then the gap before line two
	task automatic checkLine(bit eight, int gapExp);
		logic [9:0] m;
		m = eight ? 10'h3fc : 10'h3ff;
		waitLines();
		for (int j = 0; j < int'(LINE_PAIRS); j++) begin
			`CHK(grab.oddQ[j], pix(2 * j + 1) & m)
			`CHK(grab.evenQ[j], pix(2 * j + 2) & m)
		end
		`CHK(grab.gapLen, gapExp)
	endtask

	task automatic t_level10();
		start(1'b0, 1'b0, 1'b0);
		checkLine(1'b0, 7900 * 40 / 1000);
		$display("test level ten-bit done");
	endtask

	task automatic t_stretch();
		start(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 2000 && word[25] !== 1'b1; i++)
			@(negedge clk);
		repeat (170) @(negedge clk);
		syncPin = 1'b0;
		waitLines();
		`CHK(grab.gapLen, 30000 * 40 / 1000)
		$display("test stretched gap done");
	endtask

	task automatic t_prog8bin();
		start(1'b1, 1'b1, 1'b1);
		checkLine(1'b1, 7900 * 20 / 1000);
		$display("test timed eight-bit binned done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Scenarios, then the watchdog
	initial begin
		t_level10();
		t_stretch();
		t_prog8bin();
		end_sim();
	end
	initial begin
		#1000000;
		failures++;
		end_sim();
	end
endmodule // tb_top

bind dpvo_video_output dpvo_video_output_props #(
	.EXPO_CYCLES(EXPO_CYCLES)
) props (.clk, .rst_n, .linkClk, .progExposure, .eightBitMode, .binning,
	.exposure_sync_input, .oddSample, .evenSample, .exposing, .sampleTake,
	.serializer_clock_input, .serializer_parallel_input);
`default_nettype wire
